// ---- test/note_endpoint.sv ----
`timescale 1ns/1ps
`default_nettype none
module note_endpoint (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // notification stream
  input wire logic note_valid,
  input wire logic [7:0] note_byte_q,
  input wire logic slow,
  output logic note_ack
);
  logic [1:0] stall_q;
  logic [7:0] got[$];
  // ==================================================================
  // interrupt endpoint: a slow host polls one cycle in four
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      note_ack <= 1'b0;
      stall_q <= 2'h0;
    end else begin
      stall_q <= stall_q + 2'h1;
      note_ack <= note_valid && (!slow || stall_q == 2'h3);
      if (note_valid && note_ack) begin
        got.push_back(note_byte_q);
      end
    end
  end
endmodule : note_endpoint
`default_nettype wire

// ---- test/notify_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module notify_ctrl_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port and pins
  input wire notify_pkg::reg_req_t req,
  input wire logic [7:0] rdata_q,
  input wire logic [5:0] general_pin_n_in,
  input wire logic [5:0] general_pin_n_out,
  // usb side
  input wire logic class_cmd_seen,
  input wire logic [23:0] baud_rate,
  input wire logic note_ack,
  input wire logic note_valid,
  input wire logic [7:0] note_byte_q,
  input wire logic note_last,
  input wire logic wide_mode,
  input wire logic [6:0] packet_size_select
);
  import notify_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==================================================================
  // register effects and notification byte stream
  pin_high_a: assert property (req.wr && req.addr == ADDR_PIN_HIGH |=>
    (general_pin_n_out & $past(req.wdata[5:0])) == $past(req.wdata[5:0]))
    else $error("pin not driven high");
  pin_low_a: assert property (req.wr && req.addr == ADDR_PIN_LOW |=>
    (general_pin_n_out & $past(req.wdata[5:0])) == 6'h00)
    else $error("pin not driven low");
  level_read_a: assert property (req.rd && req.addr == ADDR_PIN_LEVEL |=>
    rdata_q == {2'b00, $past(general_pin_n_in)})
    else $error("pin level read wrong");
  wide_sel_a: assert property (req.wr && req.addr == ADDR_PACKET_WIDTH |=>
    wide_mode == $past(req.wdata[0])) else $error("wide mode wrong");
  size_sel_a: assert property (req.wr && req.addr == ADDR_PACKET_WIDTH
    && !class_cmd_seen |=> packet_size_select ==
    ($past(req.wdata[1]) ? PKT_SMALL : PKT_LARGE)) else $error("size wrong");
  class_size_a: assert property (class_cmd_seen |=>
    packet_size_select == PKT_SMALL) else $error("class command ignored");
  slow_baud_a: assert property (baud_rate < SLOW_BAUD_LIMIT &&
    $past(baud_rate) < SLOW_BAUD_LIMIT && req.rd && req.addr == ADDR_LATENCY
    |=> rdata_q[0]) else $error("latency not forced");
  note_hold_a: assert property (note_valid && !note_ack |=>
    note_valid && $stable(note_byte_q)) else $error("note byte dropped");
  high_zero_a: assert property (note_valid && note_last |->
    !note_byte_q[7] && !note_byte_q[2]) else $error("reserved bit set");
endmodule : notify_ctrl_assertions
bind usb_uart_gpio_notify_ctrl notify_ctrl_assertions i_notify_ctrl_assertions (
  .clk_sys(clk_sys), .rst(rst), .req(req), .rdata_q(rdata_q),
  .general_pin_n_in(general_pin_n_in), .general_pin_n_out(general_pin_n_out),
  .class_cmd_seen(class_cmd_seen), .baud_rate(baud_rate),
  .note_ack(note_ack), .note_valid(note_valid), .note_byte_q(note_byte_q),
  .note_last(note_last), .wide_mode(wide_mode),
  .packet_size_select(packet_size_select));
`default_nettype wire

// ---- test/usb_uart_gpio_notify_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module usb_uart_gpio_notify_ctrl_test;
  import notify_pkg::*;
  logic clk_sys, rst, class_cmd_seen, bulk_in_req, slow, note_ack;
  logic note_valid, note_last, rx_forward_q, wide_mode;
  reg_req_t req;
  logic [7:0] rdata_q, note_byte_q, rd_v, sel;
  logic [5:0] pin_in, pin_out, pin_oe, pv;
  logic [6:0] packet_size_select;
  logic [23:0] baud_rate;
  logic [8:0] rx_cnt;
  logic tick, rx_in;
  logic [15:0] seed;
  line_state_t line_state;
  int err_count, cmp_count, exp_out, n, w;
  int pkt[$];
  usb_uart_gpio_notify_ctrl i_usb_uart_gpio_notify_ctrl (
    .clk_sys(clk_sys), .rst(rst), .req(req), .rdata_q(rdata_q),
    .general_pin_n_in(pin_in), .general_pin_n_out(pin_out),
    .general_pin_n_oe(pin_oe), .class_cmd_seen(class_cmd_seen),
    .baud_rate(baud_rate), .bulk_in_req(bulk_in_req), .note_ack(note_ack),
    .note_valid(note_valid), .note_byte_q(note_byte_q),
    .note_last(note_last), .line_state(line_state), .rx_count(rx_cnt),
    .char_tick(tick), .rx_byte_in(rx_in), .rx_forward_q(rx_forward_q),
    .wide_mode(wide_mode), .packet_size_select(packet_size_select));
  note_endpoint host (.clk_sys(clk_sys), .rst(rst), .note_valid(note_valid),
    .note_byte_q(note_byte_q), .slow(slow), .note_ack(note_ack));
  // ==================================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 chk(rdata_q, exp);
  endtask : rdchk
  task automatic bulk(input logic [7:0] exp);
    @(posedge clk_sys);
    bulk_in_req <= 1'b1;
    @(posedge clk_sys);
    bulk_in_req <= 1'b0;
    #1 chk({7'h00, rx_forward_q}, exp);
  endtask : bulk
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // pin k lands on bit pos[k] of the high byte when selected
  function automatic int hi_byte(input logic [5:0] p, input logic [7:0] s);
    int pos[6] = '{3, 0, 1, 4, 5, 6};
    hi_byte = 0;
    for (int k = 0; k < 6; k++)
      hi_byte |= int'(p[k] & s[pos[k]]) << pos[k];
  endfunction : hi_byte
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // ==================================================================
  // stimulus
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    req = '0;
    pin_in = 6'h00;
    class_cmd_seen = 1'b0;
    bulk_in_req = 1'b0;
    rx_cnt = 9'h001;
    tick = 1'b0;
    rx_in = 1'b0;
    slow = 1'b0;
    baud_rate = 24'h01_C200;
    line_state = 7'h0B;
    seed = 16'hF16C;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(ADDR_PACKET_WIDTH, PACKET_WIDTH_RST);
    chk({1'b0, packet_size_select}, {1'b0, PKT_LARGE});
    wr(8'h20, 8'hFF);
    rdchk(8'h20, 8'h00);
    exp_out = 0;
    for (n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      wr(ADDR_PIN_HIGH, {2'b00, seed[5:0]});
      exp_out |= seed[5:0];
      chk({2'b00, pin_out}, exp_out[7:0]);
      wr(ADDR_PIN_LOW, {2'b00, seed[13:8]});
      exp_out &= ~seed[13:8];
      chk({2'b00, pin_out}, exp_out[7:0]);
      pin_in <= seed[15:10];
      rdchk(ADDR_PIN_LEVEL, {2'b00, seed[15:10]});
    end
    wr(ADDR_PACKET_WIDTH, 8'h01);
    chk({7'h00, wide_mode}, 8'h01);
    wr(ADDR_PACKET_WIDTH, 8'h02);
    chk({7'h00, wide_mode}, 8'h00);
    chk({1'b0, packet_size_select}, {1'b0, PKT_SMALL});
    wr(ADDR_PACKET_WIDTH, 8'h00);
    class_cmd_seen <= 1'b1;
    @(posedge clk_sys);
    class_cmd_seen <= 1'b0;
    rdchk(ADDR_PACKET_WIDTH, 8'h02);
    baud_rate <= 24'h00_B748;
    wr(ADDR_LATENCY, 8'h00);
    rdchk(ADDR_LATENCY, 8'h01);
    bulk(8'h01);
    baud_rate <= 24'h00_B749;
    wr(ADDR_LATENCY, 8'h00);
    rdchk(ADDR_LATENCY, 8'h00);
    bulk(8'h00);
    wr(ADDR_LATENCY, 8'h01);
    bulk(8'h01);
    wr(ADDR_LATENCY, 8'h00);
    rx_cnt <= 9'h040;
    bulk(8'h01);
    rx_cnt <= 9'h001;
    tick <= 1'b1;
    repeat (3) @(posedge clk_sys);
    tick <= 1'b0;
    bulk(8'h01);
    rx_in <= 1'b1;
    @(posedge clk_sys);
    rx_in <= 1'b0;
    bulk(8'h00);
    wr(ADDR_PIN_DIR, 8'h15);
    chk({2'b00, pin_oe}, 8'h15);
    wr(ADDR_PIN_DIR, 8'h00);
    chk({2'b00, pin_oe}, 8'h00);
    wr(ADDR_PIN_MASK, 8'h3F);
    // one pass with a prompt host, one with a stalling host
    for (n = 0; n < 2; n++) begin
      slow <= n[0];
      sel = n[0] ? 8'h52 : 8'h7B;
      wr(ADDR_PIN_SELECT, sel);
      host.got.delete();
      seed = lfsr(seed);
      pv = pin_in ^ (seed[5:0] | 6'h01);
      pin_in <= pv;
      pkt = '{8'hA1, 8'h20, 0, 0, 0, 0, 8'h02, 0, 8'h0B, hi_byte(pv, sel)};
      for (w = 0; w < 400 && host.got.size() < 10; w++)
        @(posedge clk_sys);
      if (w == 400) begin
        err_count++;
        tally_and_finish();
      end
      foreach (pkt[i]) chk(host.got[i], pkt[i][7:0]);
    end
    tally_and_finish();
  end
endmodule : usb_uart_gpio_notify_ctrl_test
`default_nettype wire

// ---- verilog/note_rom.sv ----
`timescale 1ns/1ps
`default_nettype none
module note_rom (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // lookup
  input wire logic [3:0] idx,
  input wire logic [15:0] data_word,
  output logic [7:0] byte_q
);
  import notify_pkg::*;

  logic [7:0] byte_d;

  // ==================================================================
  // packet byte table
  always_comb begin
    case (idx)
      4'h0: byte_d = NOTE_REQ_TYPE;
      4'h1: byte_d = NOTE_CODE;
      4'h2: byte_d = NOTE_VALUE[7:0];
      4'h3: byte_d = NOTE_VALUE[15:8];
      4'h4: byte_d = NOTE_INDEX[7:0];
      4'h5: byte_d = NOTE_INDEX[15:8];
      4'h6: byte_d = NOTE_LENGTH[7:0];
      4'h7: byte_d = NOTE_LENGTH[15:8];
      4'h8: byte_d = data_word[7:0];
      4'h9: byte_d = data_word[15:8];
      default: byte_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      byte_q <= 8'h00;
    end else begin
      byte_q <= byte_d;
    end
  end
endmodule : note_rom
`default_nettype wire

// ---- verilog/notify_pkg.sv ----
package notify_pkg;
  // ==================================================================
  // register offsets (index on the plain port)
  localparam logic [7:0] ADDR_PACKET_WIDTH = 8'h03;
  localparam logic [7:0] ADDR_LATENCY = 8'h04;
  localparam logic [7:0] ADDR_PIN_SELECT = 8'h06;
  localparam logic [7:0] ADDR_PIN_HIGH = 8'h10;
  localparam logic [7:0] ADDR_PIN_LOW = 8'h11;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h12;
  localparam logic [7:0] ADDR_PIN_DIR = 8'h13;
  localparam logic [7:0] ADDR_PIN_MASK = 8'h14;
  // ==================================================================
  // field positions and reset values
  localparam int WIDE_BIT = 0;
  localparam int PKT_SIZE_BIT = 1;
  localparam int LATENCY_BIT = 0;
  localparam logic [7:0] PACKET_WIDTH_RST = 8'h00;
  localparam logic [7:0] LATENCY_RST = 8'h00;
  localparam logic [7:0] PIN_SELECT_RST = 8'h00;
  localparam logic [5:0] PIN_OUT_RST = 6'h00;
  localparam logic [5:0] PIN_DIR_RST = 6'h00;
  localparam logic [5:0] PIN_MASK_RST = 6'h00;
  localparam logic [7:0] PACKET_WIDTH_MASK = 8'h03;
  localparam logic [7:0] LATENCY_MASK = 8'h01;
  localparam logic [7:0] PIN_SELECT_MASK = 8'h7B;
  // ==================================================================
  // notification layout
  localparam logic [7:0] NOTE_REQ_TYPE = 8'hA1;
  localparam logic [7:0] NOTE_CODE = 8'h20;
  localparam logic [15:0] NOTE_VALUE = 16'h0000;
  localparam logic [15:0] NOTE_INDEX = 16'h0000;
  localparam logic [15:0] NOTE_LENGTH = 16'h0002;
  localparam int NOTE_BYTES = 10;
  localparam logic [6:0] PKT_LARGE = 7'h40;
  localparam logic [6:0] PKT_SMALL = 7'h3F;
  localparam int SLOW_BAUD_LIMIT = 46921;
  localparam logic [6:0] FILL_LIMIT = 7'h40;
  localparam logic [1:0] TIMEOUT_CHARS = 2'h3;

  typedef struct packed {
    logic overrun;
    logic parity;
    logic framing;
    logic ring;
    logic brk;
    logic tx_carrier;
    logic rx_carrier;
  } line_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [1:0] {
    NOTE_IDLE = 2'b00,
    NOTE_SEND = 2'b01,
    NOTE_DONE = 2'b11
  } note_state_t;
endpackage : notify_pkg

// ---- verilog/usb_uart_gpio_notify_ctrl.sv ----
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module usb_uart_gpio_notify_ctrl #(
  parameter int PINS = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire notify_pkg::reg_req_t req,
  output logic [7:0] rdata_q,
  // general pins
  input wire logic [5:0] general_pin_n_in,
  output logic [5:0] general_pin_n_out,
  output logic [5:0] general_pin_n_oe,
  // usb side
  input wire logic class_cmd_seen,
  input wire logic [23:0] baud_rate,
  input wire logic bulk_in_req,
  input wire logic note_ack,
  output logic note_valid,
  output logic [7:0] note_byte_q,
  output logic note_last,
  // uart side
  input wire notify_pkg::line_state_t line_state,
  input wire logic [8:0] rx_count,
  input wire logic char_tick,
  input wire logic rx_byte_in,
  output logic rx_forward_q,
  output logic wide_mode,
  output logic [6:0] packet_size_select
);
  import notify_pkg::*;

  logic [7:0] pkt_width_q;
  logic [7:0] latency_q;
  logic [7:0] pin_sel_q;
  logic [5:0] pin_out_q;
  logic [5:0] pin_dir_q;
  logic [5:0] pin_mask_q;
  logic [5:0] pin_prev_q;
  logic [1:0] idle_chars_q;
  logic [6:0] err_seen_q;
  logic [6:0] reported_q;
  logic pending_q;
  note_state_t state_q;
  logic [3:0] idx_q;
  logic [15:0] data_word;
  logic [7:0] high_byte;
  logic [6:0] live_state;
  logic [6:0] line_change;
  logic pin_change;
  logic slow_baud;
  logic wr_hit_pkt;
  logic wr_hit_lat;
  logic start_note;

  function automatic logic wr_at(input reg_req_t r, input logic [7:0] a);
    wr_at = r.wr && (r.addr == a);
  endfunction : wr_at

  // ==================================================================
  // control registers
  assign wr_hit_pkt = wr_at(req, ADDR_PACKET_WIDTH);
  assign wr_hit_lat = wr_at(req, ADDR_LATENCY);
  assign slow_baud = baud_rate < 24'(SLOW_BAUD_LIMIT);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pkt_width_q <= PACKET_WIDTH_RST;
    end else begin
      if (wr_hit_pkt) begin
        pkt_width_q <= req.wdata & PACKET_WIDTH_MASK;
      end
      // hardware set wins over a software clear in the same cycle
      if (class_cmd_seen) begin
        pkt_width_q[PKT_SIZE_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latency_q <= LATENCY_RST;
    end else begin
      if (wr_hit_lat) begin
        latency_q <= req.wdata & LATENCY_MASK;
      end
      if (slow_baud) begin
        latency_q[LATENCY_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_sel_q <= PIN_SELECT_RST;
    end else if (wr_at(req, ADDR_PIN_SELECT)) begin
      pin_sel_q <= req.wdata & PIN_SELECT_MASK;
    end
  end

  assign wide_mode = pkt_width_q[WIDE_BIT];
  assign packet_size_select = pkt_width_q[PKT_SIZE_BIT] ? PKT_SMALL : PKT_LARGE;

  // ==================================================================
  // general pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_out_q <= PIN_OUT_RST;
    end else begin
      // upper bits ignored, software keeps them zero
      if (wr_at(req, ADDR_PIN_HIGH)) begin
        pin_out_q <= pin_out_q | req.wdata[5:0];
      end else if (wr_at(req, ADDR_PIN_LOW)) begin
        pin_out_q <= pin_out_q & ~req.wdata[5:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_dir_q <= PIN_DIR_RST;
      pin_mask_q <= PIN_MASK_RST;
    end else begin
      if (wr_at(req, ADDR_PIN_DIR)) begin
        pin_dir_q <= req.wdata[5:0];
      end
      if (wr_at(req, ADDR_PIN_MASK)) begin
        pin_mask_q <= req.wdata[5:0];
      end
    end
  end

  assign general_pin_n_out = pin_out_q;
  assign general_pin_n_oe = pin_dir_q;

  // ==================================================================
  // read path, unmapped reads return zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_PACKET_WIDTH: rdata_q <= pkt_width_q;
        ADDR_LATENCY: rdata_q <= latency_q;
        ADDR_PIN_SELECT: rdata_q <= pin_sel_q;
        ADDR_PIN_LEVEL: rdata_q <= {2'b00, general_pin_n_in};
        ADDR_PIN_DIR: rdata_q <= {2'b00, pin_dir_q};
        ADDR_PIN_MASK: rdata_q <= {2'b00, pin_mask_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ==================================================================
  // receive forwarding
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_chars_q <= 2'b00;
    end else if (rx_byte_in || rx_count == 9'h000) begin
      idle_chars_q <= 2'b00;
    end else if (char_tick && idle_chars_q != TIMEOUT_CHARS) begin
      idle_chars_q <= idle_chars_q + 2'b01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_forward_q <= 1'b0;
    end else if (latency_q[LATENCY_BIT]) begin
      rx_forward_q <= bulk_in_req && rx_count != 9'h000;
    end else begin
      rx_forward_q <= bulk_in_req && (rx_count >= {2'b00, FILL_LIMIT}
        || (idle_chars_q == TIMEOUT_CHARS && rx_count != 9'h000));
    end
  end

  // ==================================================================
  // notification data word
  // sel bit order: 0 pin1, 1 pin2, 3 pin0, 4 pin3, 5 pin4, 6 pin5
  always_comb begin
    high_byte = 8'h00;
    high_byte[0] = pin_sel_q[0] & general_pin_n_in[1];
    high_byte[1] = pin_sel_q[1] & general_pin_n_in[2];
    high_byte[3] = pin_sel_q[3] & general_pin_n_in[0];
    high_byte[4] = pin_sel_q[4] & general_pin_n_in[3];
    high_byte[5] = pin_sel_q[5] & general_pin_n_in[4];
    high_byte[6] = pin_sel_q[6] & general_pin_n_in[5];
  end

  // sticky errors: held until a packet carrying them is sent
  assign live_state = line_state | {err_seen_q[6:4], 4'h0};
  assign data_word = {high_byte, 1'b0, live_state};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_seen_q <= 7'h00;
    end else begin
      // new error wins over the clear after reporting
      if (state_q == NOTE_DONE) begin
        err_seen_q <= {line_state[6:4], 4'h0};
      end else begin
        err_seen_q <= err_seen_q | {line_state[6:4], 4'h0};
      end
    end
  end

  // ==================================================================
  // change detection
  assign line_change = live_state ^ reported_q;
  assign pin_change =
    |((general_pin_n_in ^ pin_prev_q) & pin_mask_q & ~pin_dir_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_prev_q <= 6'h00;
    end else begin
      pin_prev_q <= general_pin_n_in;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pending_q <= 1'b0;
    end else if (pin_change || line_change != 7'h00) begin
      pending_q <= 1'b1;
    end else if (start_note) begin
      pending_q <= 1'b0;
    end
  end

  // ==================================================================
  // packet sender, one byte per ack
  assign start_note = state_q == NOTE_IDLE && pending_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= NOTE_IDLE;
      idx_q <= 4'h0;
      reported_q <= 7'h00;
    end else begin
      case (state_q)
        NOTE_IDLE: begin
          idx_q <= 4'h0;
          if (pending_q) begin
            state_q <= NOTE_SEND;
            reported_q <= live_state;
          end
        end
        NOTE_SEND: begin
          // only a real handshake advances; a stray ack is not a byte
          if (note_valid && note_ack) begin
            if (idx_q == 4'(NOTE_BYTES - 1)) begin
              state_q <= NOTE_DONE;
            end else begin
              idx_q <= idx_q + 4'h1;
            end
          end
        end
        NOTE_DONE: begin
          state_q <= NOTE_IDLE;
          reported_q <= reported_q & 7'h0F;
        end
        default: state_q <= NOTE_IDLE;
      endcase
    end
  end

  // byte register lags index by one cycle; valid waits for it
  logic byte_ready_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      byte_ready_q <= 1'b0;
    end else begin
      byte_ready_q <= state_q == NOTE_SEND && !(note_valid && note_ack);
    end
  end

  assign note_valid = state_q == NOTE_SEND && byte_ready_q;
  assign note_last = note_valid && idx_q == 4'(NOTE_BYTES - 1);

  note_rom u_rom (
    .clk_sys(clk_sys),
    .rst(rst),
    .idx(idx_q),
    .data_word(data_word),
    .byte_q(note_byte_q)
  );
endmodule : usb_uart_gpio_notify_ctrl
`default_nettype wire
